/* File: inc/pwm_pkg.sv */
// Shared constants for the pulse-width channel block
package pwm_pkg;
  // Sizes
  localparam int NCH    = 4;
  localparam int CHW    = 2;
  localparam int PW     = 16;
  localparam int ADDR_W = 8;
  localparam int CFG_W  = 6;

  // Duty scaling
  localparam logic [PW-1:0] DUTY_FULL  = 16'h8000;
  localparam int            DUTY_SHIFT = 15;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CMD    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DUTY   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CFG    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RUNPER = 8'h20;
  localparam logic [ADDR_W-1:0] REG_END    = 8'h30;

  // Command word fields and codes
  localparam int        CMD_OP_LSB = 0;
  localparam int        CMD_CH_LSB = 4;
  localparam logic [1:0] OP_DUTY   = 2'h1;
  localparam logic [1:0] OP_PD     = 2'h2;
  localparam logic [1:0] OP_IDLE   = 2'h3;

  // Channel config fields
  localparam int         CFG_POL       = 0;
  localparam int         CFG_IDLE      = 1;
  localparam int         CFG_CLASS_LSB = 2;
  localparam int         CFG_DEFD      = 4;
  localparam int         CFG_DEFP      = 5;
  localparam logic [1:0] CLS_FIXED     = 2'h0;
  localparam logic [1:0] CLS_SHIFT     = 2'h1;
  localparam logic [1:0] CLS_VAR       = 2'h2;

  // Status fields
  localparam int ST_PWM_LSB  = 0;
  localparam int ST_IDLE_LSB = 8;
  localparam int ST_PEND_LSB = 16;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST    = 6'h00;
  localparam logic [PW-1:0]    STAGE_RST  = 16'h0000;
  localparam logic [PW-1:0]    PERIOD_DEF = 16'h0064;
  localparam logic [PW-1:0]    DUTY_DEF   = 16'h0000;

  // Build-time options
  localparam logic DUTY_CMD_PRESENT   = 1'b1;
  localparam logic PD_CMD_PRESENT     = 1'b1;
  localparam logic IDLE_CMD_PRESENT   = 1'b1;
  localparam logic DEFER_DUTY_BUILT   = 1'b1;
  localparam logic DEFER_PERIOD_BUILT = 1'b1;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/pwm_lane.sv */
// One pulse-width channel: counter, comparator, pending update, idle
`timescale 1ns/1ps
module pwm_lane (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Command strobes and values
  input  wire logic                  i_duty_cmd,
  input  wire logic                  i_pd_cmd,
  input  wire logic                  i_idle_cmd,
  input  wire logic [pwm_pkg::PW-1:0] i_duty,
  input  wire logic [pwm_pkg::PW-1:0] i_period,
  // Channel configuration
  input  wire logic                  i_pol,
  input  wire logic                  i_idle_lvl,
  input  wire logic                  i_variable,
  input  wire logic                  i_defer_duty,
  input  wire logic                  i_defer_period,
  // Channel state
  output logic                       o_pwm,
  output logic                       o_idle,
  output logic                       o_pend,
  output logic [pwm_pkg::PW-1:0]     o_period
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic [PW-1:0] per;
    logic [PW-1:0] duty;
    logic [PW-1:0] thr;
    logic [PW-1:0] pend_duty;
    logic [PW-1:0] pend_per;
    logic          pend;
    logic          pend_per_ok;
    logic          idle;
    logic          pwm;
  } lane_t;

  lane_t q;
  lane_t next_q;
  logic  bnd;
  logic  defer;
  logic  [PW-1:0] per_a;

  function automatic logic [PW-1:0] clamp(input logic [PW-1:0] d);
    return (d > DUTY_FULL) ? DUTY_FULL : d;
  endfunction

  function automatic logic [PW-1:0] thr_of(input logic [PW-1:0] p,
                                            input logic [PW-1:0] d);
    logic [2*PW-1:0] prod;
    prod = p * d;
    return prod[DUTY_SHIFT +: PW];
  endfunction

  always_comb begin
    next_q = q;
    per_a  = q.per;
    bnd    = (q.per == '0) || (q.cnt == q.per - 16'h0001);
    next_q.cnt = bnd ? '0 : q.cnt + 16'h0001;
    defer = q.pend_per_ok ? (i_defer_period && DEFER_PERIOD_BUILT)
                          : (i_defer_duty && DEFER_DUTY_BUILT);
    // Pending pair lands only at a period boundary unless stopped and not deferred
    if (q.pend && (bnd || (!defer && (q.idle || q.per == '0)))) begin
      per_a            = q.pend_per_ok ? q.pend_per : q.per;
      next_q.per       = per_a;
      next_q.duty      = q.pend_duty;
      next_q.thr       = thr_of(per_a, q.pend_duty);
      next_q.idle      = 1'b0;
      next_q.pend      = 1'b0;
      if (!bnd) begin
        next_q.cnt = '0;
      end
    end
    if (i_idle_cmd) begin
      next_q.idle = 1'b1;
      next_q.pend = 1'b0;
    end else if (i_duty_cmd || i_pd_cmd) begin
      next_q.pend        = 1'b1;
      next_q.pend_duty   = clamp(i_duty);
      next_q.pend_per_ok = i_pd_cmd && i_variable;
      next_q.pend_per    = i_period;
    end
    if (next_q.idle) begin
      next_q.pwm = i_idle_lvl;
    end else if (next_q.per == '0) begin
      next_q.pwm = ~i_pol;
    end else begin
      next_q.pwm = (next_q.cnt < next_q.thr) ? i_pol : ~i_pol;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q      <= '0;
      q.per  <= PERIOD_DEF;
      q.duty <= DUTY_DEF;
      q.thr  <= thr_of(PERIOD_DEF, DUTY_DEF);
      q.idle <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign o_pwm    = q.pwm;
  assign o_idle   = q.idle;
  assign o_pend   = q.pend;
  assign o_period = q.per;

  zero_per_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (q.per == '0 && !q.idle && $stable(i_pol)) |-> q.pwm != i_pol)
    else $error("zero period output not inactive");
  full_duty_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (q.duty == DUTY_FULL && q.per != '0 && !q.idle && $stable(i_pol))
    |-> q.pwm == i_pol)
    else $error("full duty output not active");
  zero_duty_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (q.duty == '0 && !q.idle && $stable(i_pol)) |-> q.pwm != i_pol)
    else $error("zero duty output not inactive");
  duty_clamp_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_duty_cmd ##1 q.pend |-> q.pend_duty <= DUTY_FULL)
    else $error("duty not clamped");
  cnt_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
    q.per != '0 |-> q.cnt < q.per)
    else $error("counter beyond period");
  defer_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (q.pend && !q.idle && q.per != '0 && q.cnt != q.per - 16'h0001)
    |=> $stable(q.duty) && $stable(q.per))
    else $error("update landed inside a period");
  idle_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (q.idle && !q.pend) |=> q.idle)
    else $error("idle left without command");
  fixed_per_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pd_cmd && !i_variable && !i_idle_cmd) |=> !q.pend_per_ok)
    else $error("fixed channel took a period");
endmodule

/* File: logic/pwm_channel_duty_period_update.sv */
// Multi-channel pulse-width generator with AXI4-Lite command registers
`timescale 1ns/1ps
module pwm_channel_duty_period_update (
  // Clock and reset
  input  wire logic                          I_SYS_CLK,
  input  wire logic                          I_SYS_RST,
  // AXI4-Lite write address
  input  wire logic [pwm_pkg::ADDR_W-1:0]    I_AWADDR,
  input  wire logic                          I_AWVALID,
  output logic                               O_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]                   I_WDATA,
  input  wire logic [3:0]                    I_WSTRB,
  input  wire logic                          I_WVALID,
  output logic                               O_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                         O_BRESP,
  output logic                               O_BVALID,
  input  wire logic                          I_BREADY,
  // AXI4-Lite read address
  input  wire logic [pwm_pkg::ADDR_W-1:0]    I_ARADDR,
  input  wire logic                          I_ARVALID,
  output logic                               O_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                        O_RDATA,
  output logic [1:0]                         O_RRESP,
  output logic                               O_RVALID,
  input  wire logic                          I_RREADY,
  // Channel outputs
  output logic [pwm_pkg::NCH-1:0]            O_PWM
);
  import pwm_pkg::*;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_t;

  typedef struct packed {
    wr_state_t                 wr_st;
    logic                      awready;
    logic                      wready;
    logic                      aw_have;
    logic                      w_have;
    logic [ADDR_W-1:0]         awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic [PW-1:0]             duty_stage;
    logic [PW-1:0]             per_stage;
    logic [NCH-1:0][CFG_W-1:0] cfg;
    logic [NCH-1:0]            cmd_duty;
    logic [NCH-1:0]            cmd_pd;
    logic [NCH-1:0]            cmd_idle;
  } top_t;

  top_t q;
  top_t next_q;

  logic [NCH-1:0]         lane_pwm;
  logic [NCH-1:0]         lane_idle;
  logic [NCH-1:0]         lane_pend;
  logic [NCH-1:0][PW-1:0] lane_per;

  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic [31:0]       wv;
  logic [31:0]       rd;
  logic [1:0]        op;
  logic [CHW-1:0]    ch;

  // Word-aligned address inside the map
  function automatic logic known(input logic [ADDR_W-1:0] a);
    return a < REG_END;
  endfunction

  // Config slot index of an address
  function automatic logic [CHW-1:0] slot(input logic [ADDR_W-1:0] a);
    return a[2 +: CHW];
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = val[8*b +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    next_q   = q;
    wa       = {q.awaddr[ADDR_W-1:2], 2'b00};
    ra       = {I_ARADDR[ADDR_W-1:2], 2'b00};
    wv       = '0;
    rd       = '0;
    op       = q.wdata[CMD_OP_LSB +: 2];
    ch       = q.wdata[CMD_CH_LSB +: CHW];
    next_q.cmd_duty = '0;
    next_q.cmd_pd   = '0;
    next_q.cmd_idle = '0;

    // Write channel capture, either order
    if (I_AWVALID && q.awready) begin
      next_q.awaddr  = I_AWADDR;
      next_q.aw_have = 1'b1;
      next_q.awready = 1'b0;
    end
    if (I_WVALID && q.wready) begin
      next_q.wdata  = I_WDATA;
      next_q.wstrb  = I_WSTRB;
      next_q.w_have = 1'b1;
      next_q.wready = 1'b0;
    end

    case (q.wr_st)
      WR_COLLECT: begin
        if (q.aw_have && q.w_have) begin
          next_q.bvalid = 1'b1;
          next_q.bresp  = known(wa) ? RESP_OKAY : RESP_SLVERR;
          next_q.wr_st  = WR_RESP;
          if (wa == REG_CMD && q.wstrb[0]) begin
            if (op == OP_DUTY && DUTY_CMD_PRESENT) begin
              next_q.cmd_duty[ch] = 1'b1;
            end
            if (op == OP_PD && PD_CMD_PRESENT) begin
              next_q.cmd_pd[ch] = 1'b1;
            end
            if (op == OP_IDLE && IDLE_CMD_PRESENT) begin
              next_q.cmd_idle[ch] = 1'b1;
            end
          end else if (wa == REG_DUTY) begin
            wv = merge({16'h0000, q.duty_stage}, q.wdata, q.wstrb);
            next_q.duty_stage = wv[PW-1:0];
          end else if (wa == REG_PERIOD) begin
            wv = merge({16'h0000, q.per_stage}, q.wdata, q.wstrb);
            next_q.per_stage = wv[PW-1:0];
          end else if (wa >= REG_CFG && wa < REG_RUNPER) begin
            wv = merge({26'h000_0000, q.cfg[slot(wa)]},
                       q.wdata, q.wstrb);
            next_q.cfg[slot(wa)] = wv[CFG_W-1:0];
          end
        end
      end
      WR_RESP: begin
        if (I_BREADY) begin
          next_q.bvalid  = 1'b0;
          next_q.aw_have = 1'b0;
          next_q.w_have  = 1'b0;
          next_q.awready = 1'b1;
          next_q.wready  = 1'b1;
          next_q.wr_st   = WR_COLLECT;
        end
      end
      default: begin
        next_q.wr_st = WR_COLLECT;
      end
    endcase

    // Read mux
    if (ra == REG_DUTY) begin
      rd[PW-1:0] = q.duty_stage;
    end else if (ra == REG_PERIOD) begin
      rd[PW-1:0] = q.per_stage;
    end else if (ra == REG_STATUS) begin
      rd[ST_PWM_LSB +: NCH]  = lane_pwm;
      rd[ST_IDLE_LSB +: NCH] = lane_idle;
      rd[ST_PEND_LSB +: NCH] = lane_pend;
    end else if (ra >= REG_CFG && ra < REG_RUNPER) begin
      rd[CFG_W-1:0] = q.cfg[slot(ra)];
    end else if (ra >= REG_RUNPER && known(ra)) begin
      rd[PW-1:0] = lane_per[slot(ra)];
    end

    if (I_ARVALID && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid  = 1'b1;
      next_q.rdata   = rd;
      next_q.rresp   = known(ra) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && I_RREADY) begin
      next_q.rvalid  = 1'b0;
      next_q.arready = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      q            <= '0;
      q.wr_st      <= WR_COLLECT;
      q.awready    <= 1'b1;
      q.wready     <= 1'b1;
      q.arready    <= 1'b1;
      q.bresp      <= RESP_OKAY;
      q.rresp      <= RESP_OKAY;
      q.duty_stage <= STAGE_RST;
      q.per_stage  <= STAGE_RST;
      q.cfg        <= {NCH{CFG_RST}};
    end else begin
      q <= next_q;
    end
  end

  // One lane per channel, each on its own strobes
  for (genvar g = 0; g < NCH; g++) begin : g_lane
    pwm_lane u_lane (
      .i_clk          (I_SYS_CLK),
      .i_rst          (I_SYS_RST),
      .i_duty_cmd     (q.cmd_duty[g]),
      .i_pd_cmd       (q.cmd_pd[g]),
      .i_idle_cmd     (q.cmd_idle[g]),
      .i_duty         (q.duty_stage),
      .i_period       (q.per_stage),
      .i_pol          (q.cfg[g][CFG_POL]),
      .i_idle_lvl     (q.cfg[g][CFG_IDLE]),
      .i_variable     (q.cfg[g][CFG_CLASS_LSB +: 2] == CLS_VAR),
      .i_defer_duty   (q.cfg[g][CFG_DEFD]),
      .i_defer_period (q.cfg[g][CFG_DEFP]),
      .o_pwm          (lane_pwm[g]),
      .o_idle         (lane_idle[g]),
      .o_pend         (lane_pend[g]),
      .o_period       (lane_per[g])
    );

    idle_now_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_SYS_RST)
      (q.cmd_idle[g] && $stable(q.cfg[g]))
      |=> lane_pwm[g] == q.cfg[g][CFG_IDLE] && lane_idle[g])
      else $error("idle level not reached next cycle");

    restart_a: assert property (@(posedge I_SYS_CLK)
      disable iff (I_SYS_RST)
      (lane_idle[g] && !lane_pend[g] && q.cmd_duty[g] == 1'b0
       && q.cmd_pd[g] == 1'b0) |=> lane_idle[g])
      else $error("lane left idle on its own");
  end

  assign O_AWREADY = q.awready;
  assign O_WREADY  = q.wready;
  assign O_BRESP   = q.bresp;
  assign O_BVALID  = q.bvalid;
  assign O_ARREADY = q.arready;
  assign O_RDATA   = q.rdata;
  assign O_RRESP   = q.rresp;
  assign O_RVALID  = q.rvalid;
  assign O_PWM     = lane_pwm;

  // Checks on the command path and the bus
  sel_only_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    $onehot0({q.cmd_duty, q.cmd_pd, q.cmd_idle}))
    else $error("command reached more than one lane");

  cmd_src_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    (|{q.cmd_duty, q.cmd_pd, q.cmd_idle})
    |-> $past(q.wr_st == WR_COLLECT && q.aw_have && q.w_have)
        && q.wr_st == WR_RESP)
    else $error("command strobe without a command write");

  no_block_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    (q.wr_st == WR_COLLECT && q.aw_have && q.w_have)
    |=> q.bvalid)
    else $error("write answer delayed");

  bresp_hold_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    (q.bvalid && !I_BREADY) |=> q.bvalid && $stable(q.bresp))
    else $error("write answer dropped early");

  rd_err_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    (I_ARVALID && q.arready && !known({I_ARADDR[ADDR_W-1:2], 2'b00}))
    |=> q.rvalid && q.rresp == RESP_SLVERR)
    else $error("unmapped read not refused");

  rd_lat_a: assert property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    (I_ARVALID && q.arready) |=> q.rvalid && !q.arready)
    else $error("read answer not one cycle later");

  duty_cov: cover property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    q.cmd_duty[1] ##[1:40] !lane_pend[1]);

  pd_cov: cover property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    q.cmd_pd[1] ##[1:40] !lane_pend[1]);

  idle_cov: cover property (@(posedge I_SYS_CLK)
    disable iff (I_SYS_RST)
    q.cmd_idle[2] ##1 lane_idle[2]);
endmodule

/* File: tb/pwm_channel_duty_period_update_tb.sv */
// Self-checking testbench for the pulse-width channel block
`timescale 1ns/1ps
module pwm_channel_duty_period_update_tb;
  import pwm_pkg::*;
  logic              clk, rst;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rs;
  logic [NCH-1:0]    pwm;
  int                mismatches, total_checks, hi, polls;

  pwm_channel_duty_period_update dut (
    .I_SYS_CLK (clk),     .I_SYS_RST (rst),
    .I_AWADDR  (awaddr),  .I_AWVALID (awvalid), .O_AWREADY (awready),
    .I_WDATA   (wdata),   .I_WSTRB   (wstrb),   .I_WVALID  (wvalid),
    .O_WREADY  (wready),  .O_BRESP   (bresp),   .O_BVALID  (bvalid),
    .I_BREADY  (bready),  .I_ARADDR  (araddr),  .I_ARVALID (arvalid),
    .O_ARREADY (arready), .O_RDATA   (rdata),   .O_RRESP   (rresp),
    .O_RVALID  (rvalid),  .I_RREADY  (rready),  .O_PWM     (pwm)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write one word; handshakes are sampled at the settled negedge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    int   n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = bvalid;
      rs    = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) begin
        bready <= 1'b0;
        break;
      end
      if (++n > 100) begin
        mismatches++;
        break;
      end
    end
  endtask

  task automatic rdw(input logic [7:0] a);
    logic ar_ok, r_ok;
    int   n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok  = rvalid;
      rd    = rdata;
      rs    = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) begin
        rready <= 1'b0;
        break;
      end
      if (++n > 100) begin
        mismatches++;
        break;
      end
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rdw(a);
    chk(rd, exp);
    chk(rs, RESP_OKAY);
  endtask

  task automatic cmd(input logic [1:0] op, input logic [1:0] ch);
    wr(REG_CMD, {26'h0, ch, 2'h0, op});
  endtask

  // Count active-high cycles of one channel over a window
  task automatic cnt(input int ch, input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      if (pwm[ch] === 1'b1) hi++;
    end
  endtask

  initial begin
    #300000;
    mismatches++;
    conclude();
  end

  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    mismatches = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset state and bus errors
    chk(pwm, 32'h0000_0000);
    rchk(REG_STATUS, 32'h0000_0F00);
    rchk(REG_RUNPER, 32'h0000_0064);
    wr(REG_END, 32'h0000_0001);
    chk(rs, RESP_SLVERR);
    rdw(REG_END + 8'h04);
    chk(rd, 32'h0000_0000);
    chk(rs, RESP_SLVERR);
    // Channel setup: 0 variable, 1 and 2 fixed, 3 variable deferred
    wr(REG_CFG, 32'h0000_0009);
    rchk(REG_CFG, 32'h0000_0009);
    wr(REG_CFG + 8'h04, 32'h0000_0001);
    wr(REG_CFG + 8'h08, 32'h0000_0001);
    wr(REG_CFG + 8'h0C, 32'h0000_0039);
    rchk(REG_CFG + 8'h0C, 32'h0000_0039);
    // Combined start of a variable channel at half duty
    wr(REG_PERIOD, 32'h0000_0004);
    wr(REG_DUTY, 32'h0000_4000);
    cmd(OP_PD, 2'd0);
    rchk(REG_RUNPER, 32'h0000_0004);
    cnt(0, 16);
    chk(hi, 8);
    // Full duty, then idle, then restart on a fixed channel
    wr(REG_DUTY, 32'h0000_8000);
    cmd(OP_DUTY, 2'd1);
    repeat (3) @(negedge clk);
    cnt(1, 20);
    chk(hi, 20);
    cmd(OP_IDLE, 2'd1);
    @(negedge clk);
    @(negedge clk);
    chk(pwm[1], 1'b0);
    cnt(1, 40);
    chk(hi, 0);
    cmd(OP_DUTY, 2'd1);
    repeat (3) @(negedge clk);
    chk(pwm[1], 1'b1);
    wr(REG_PERIOD, 32'h0000_0008);
    cmd(OP_PD, 2'd1);
    rchk(REG_RUNPER + 8'h04, 32'h0000_0064);
    // Clamp above full scale, then drop to zero duty
    wr(REG_DUTY, 32'h0000_FFFF);
    cmd(OP_DUTY, 2'd2);
    repeat (3) @(negedge clk);
    cnt(2, 10);
    chk(hi, 10);
    wr(REG_DUTY, 32'h0000_0000);
    cmd(OP_DUTY, 2'd2);
    repeat (110) @(negedge clk);
    cnt(2, 100);
    chk(hi, 0);
    cnt(0, 16);
    chk(hi, 8);
    // Deferred period on channel 3
    wr(REG_PERIOD, 32'h0000_0032);
    wr(REG_DUTY, 32'h0000_4000);
    cmd(OP_PD, 2'd3);
    // Deferred start waits for a boundary of the default period
    polls = 0;
    rdw(REG_RUNPER + 8'h0C);
    while (rd !== 32'h0000_0032 && polls < 40) begin
      rdw(REG_RUNPER + 8'h0C);
      polls++;
    end
    chk(rd, 32'h0000_0032);
    wr(REG_PERIOD, 32'h0000_000A);
    cmd(OP_PD, 2'd3);
    rchk(REG_RUNPER + 8'h0C, 32'h0000_0032);
    rdw(REG_STATUS);
    chk(rd[19], 1'b1);
    repeat (60) @(negedge clk);
    rchk(REG_RUNPER + 8'h0C, 32'h0000_000A);
    // Zero period forces the inactive level
    wr(REG_PERIOD, 32'h0000_0000);
    cmd(OP_PD, 2'd0);
    repeat (10) @(negedge clk);
    cnt(0, 20);
    chk(hi, 0);
    rchk(REG_RUNPER, 32'h0000_0000);
    conclude();
  end
endmodule
